// ---- dv/tb_top.sv ----
// Purpose: Self-checking bench for the dual wiper host controller.
// Assumes: Device models start at stored position 0, like the shadow.
// Notes:   Store wait is cut to 20 cycles to keep the run short.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam   SC = 20;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        cmd_valid = 1'b0;
    logic        cmd_chan = 1'b0;
    logic [1:0]  cmd_op = 2'h0;
    logic        cmd_up = 1'b0;
    wire         cmd_ready, busy, sel0_n, step0_n, dir0, sel1_n, step1_n, dir1;
    wire  [4:0]  pos0, pos1, cnt0, cnt1, nv0, nv1;
    int          n_mismatch = 0;
    int          samples_checked = 0;
    int          e [2] = '{0, 0};
    int          nvx [2] = '{0, 0};
    logic [31:0] seed = 32'h0000AC97;
    udw_host #(.STORE_CYCLES(SC)) dut_u (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_chan(cmd_chan), .cmd_op(cmd_op), .cmd_up(cmd_up),
        .pos0(pos0), .pos1(pos1), .busy(busy), .sel0_n(sel0_n), .step0_n(step0_n),
        .dir0(dir0), .sel1_n(sel1_n), .step1_n(step1_n), .dir1(dir1));
    udw_dev dev0_u (.sel_n(sel0_n), .step_n(step0_n), .up(dir0), .cnt(cnt0), .nv(nv0));
    udw_dev dev1_u (.sel_n(sel1_n), .step_n(step1_n), .up(dir1), .cnt(cnt1), .nv(nv1));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string nm, input int ex, input logic [4:0] got);
        samples_checked++;
        if (got !== ex[4:0]) begin
            n_mismatch++;
            $display("MISMATCH %s expected %0d seen %0d", nm, ex, got);
        end
    endtask
    task automatic close_out();
        $display("TB: %0d checks, %0d mismatches", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic run(input logic c, input logic [1:0] op, input logic u);
        int k;
        k = 0;
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_chan <= c;
        cmd_op <= op;
        cmd_up <= u;
        do @(negedge mclk); while (cmd_ready !== 1'b1);
        @(posedge mclk);
        cmd_valid <= 1'b0;
        repeat (2) @(negedge mclk);
        while ((busy !== 1'b0 || cmd_ready !== 1'b1) && k < 500) begin
            @(negedge mclk);
            k++;
        end
        if (k >= 500) begin
            n_mismatch++;
            $display("MISMATCH busy expected 0 seen %0b", busy);
        end
        if (op == 2'h0) e[c] = u ? (e[c] < 31 ? e[c] + 1 : 31) : (e[c] > 0 ? e[c] - 1 : 0);
        if (op == 2'h1) nvx[c] = e[c];
        chk("pos0", e[0], pos0);
        chk("pos1", e[1], pos1);
        chk("wiper0", e[0], cnt0);
        chk("wiper1", e[1], cnt1);
        chk("stored0", nvx[0], nv0);
        chk("stored1", nvx[1], nv1);
    endtask
    initial forever #50 mclk = ~mclk;
    initial begin
        #2000000;
        n_mismatch++;
        close_out();
    end
    initial begin
        int c;
        int n;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(negedge mclk);
        chk("idle_pins", 15, {1'b0, sel0_n, step0_n, sel1_n, step1_n});
        // The first two blocks run past both ends to reach saturation.
        for (int t = 0; t < 12; t++) begin
            c = (t < 2) ? 0 : int'(rnd() & 32'h1);
            n = (t < 2) ? 36 : int'(rnd() % 6) + 1;
            for (int i = 0; i < n; i++) run(c[0], 2'h0, (t == 0) || (t > 1 && rnd() & 1));
            run(c[0], t[0] ? 2'h2 : 2'h1, 1'b0);
            $display("TB: test %0d done", t);
        end
        // An end with no channel selected must be ignored, leaving busy low and pins idle.
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_op <= 2'h1;
        repeat (4) @(posedge mclk);
        cmd_valid <= 1'b0;
        @(negedge mclk);
        chk("refused_end", 15, {busy, sel0_n, step0_n, sel1_n, step1_n});
        close_out();
    end
endmodule
bind udw_host udw_chk #(.STORE_CYCLES(STORE_CYCLES)) chk_u (.mclk(mclk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_chan(cmd_chan), .cmd_op(cmd_op),
    .sel0_n(sel0_n), .step0_n(step0_n), .dir0(dir0), .sel1_n(sel1_n), .step1_n(step1_n));
`default_nettype wire

// ---- dv/udw_chk_assertions.sv ----
// Purpose: Pin timing checks on the wiper host controller.
// Assumes: Bound to the host; one clock, synchronous reset.
// Notes:   Channel 0 only, except the reset check on both; both channels share the same sequencer.
`timescale 1ns/1ps
`default_nettype none
module udw_chk #(
    parameter STORE_CYCLES = 20
) (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       rst,
    // Command port
    input wire logic       cmd_valid,
    input wire logic       cmd_ready,
    input wire logic       cmd_chan,
    input wire logic [1:0] cmd_op,
    // Device pins
    input wire logic       sel0_n,
    input wire logic       step0_n,
    input wire logic       dir0,
    input wire logic       sel1_n,
    input wire logic       step1_n
);
    logic [31:0] gap;
    wire         take = cmd_valid && cmd_ready;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // Counts cycles since a storing deselect, so a too early reselect shows.
    always @(posedge mclk) begin
        if (rst) gap <= 32'hFFFFFFFF;
        else if ($rose(sel0_n) && step0_n) gap <= 32'h0;
        else if (gap != 32'hFFFFFFFF) gap <= gap + 32'h1;
    end
    reset_idle_a: assert property ($fell(rst) |-> sel0_n && sel1_n && step0_n && step1_n)
        else $error("Pins not idle after reset.");
    store_wait_a: assert property ($fell(sel0_n) |-> gap >= STORE_CYCLES - 1)
        else $error("Reselect inside store time.");
    nostore_low_a: assert property (take && cmd_op == 2'h2 && !sel0_n
        |-> ##[1:40] ($rose(sel0_n) && !step0_n))
        else $error("Deselect without store not done with step low.");
    store_high_a: assert property (take && cmd_op == 2'h1 && !sel0_n
        |-> ##[1:40] ($rose(sel0_n) && step0_n))
        else $error("Store deselect not done with step high.");
    step_sel_a: assert property ($fell(step0_n) |-> !sel0_n && !$past(sel0_n))
        else $error("Step edge without select setup.");
    dir_setup_a: assert property ($fell(step0_n) |-> $stable(dir0))
        else $error("Direction changed at step edge.");
    no_toggle_a: assert property ($fell(sel0_n) |-> step0_n && $past(step0_n))
        else $error("Select fell with step low.");
    step_issue_a: assert property (take && cmd_op == 2'h0 && !cmd_chan
        |-> ##[13:15] $fell(step0_n))
        else $error("Step command gave no step edge.");
endmodule
`default_nettype wire

// ---- dv/udw_dev.sv ----
// Purpose: Behavioural model of one device channel behind the host pins.
// Assumes: Stored position starts at zero and is recalled at power-up.
// Notes:   The store is instant; the store-time wait is judged by the checker on channel 0 only.
`timescale 1ns/1ps
`default_nettype none
module udw_dev (
    // Device pins
    input  wire logic       sel_n,
    input  wire logic       step_n,
    input  wire logic       up,
    // Observed state
    output logic      [4:0] cnt,
    output logic      [4:0] nv
);
    wire [31:0] tap = 32'h1 << cnt;
    initial begin
        nv = 5'h00;
        cnt = 5'h00;
    end
    // Only this channel's pins reach it, so two instances stay independent.
    always @(negedge step_n) begin
        if (sel_n === 1'b0) begin
            if (up && cnt != 5'h1F) cnt <= cnt + 5'h01;
            else if (!up && cnt != 5'h00) cnt <= cnt - 5'h01;
        end
    end
    always @(posedge sel_n) begin
        if (step_n === 1'b1) nv <= cnt;
    end
endmodule
`default_nettype wire

// ---- hdl/udw_consts.vh ----
// Purpose: Timing counts and codes for the dual wiper pin controller.
// Assumes: mclk at 10 MHz, 100 ns period.
// Notes:   Times are in ns; cycle counts derive from them.
`ifndef UDW_CONSTS_VH
`define UDW_CONSTS_VH
`define UDW_CLK_PERIOD_NS     100
`define UDW_CS_TO_STEP_NS     100
`define UDW_DIR_SETUP_NS      100
`define UDW_STEP_LOW_NS       1000
`define UDW_STEP_HIGH_NS      1000
`define UDW_STEP_TO_CS_NS     1000
`define UDW_DESEL_NOSTORE_NS  250
`define UDW_STORE_CYCLE_NS    10000000
`define UDW_CYC(ns) (((ns) + `UDW_CLK_PERIOD_NS - 1) / `UDW_CLK_PERIOD_NS)
`define UDW_CNT_W             17
`define UDW_POS_W             5
`define UDW_POS_MAX           5'h1F
`define UDW_OP_STEP           2'h0
`define UDW_OP_END_STORE      2'h1
`define UDW_OP_END_NOSTORE    2'h2
`endif

// ---- hdl/udw_host.v ----
// Purpose: Host controller driving select, step and direction pins of a
//          dual up/down wiper device, with a shadow of each wiper position.
// Assumes: Pins are plain outputs; the device powers up with select high.
// Notes:   One command is run at a time on one channel.
//          A step leaves its pin low until the next command lifts it.
// Notes on behaviour
// - Step low while raising select skips store.
// - Hold select high from power-up.
// - Direction may change while still selected.
// - Never move wiper by toggling select.
// - Wait store cycle time before reselecting.
`timescale 1ns/1ps
`default_nettype none
`include "udw_consts.vh"
module udw_host #(
    parameter STORE_CYCLES = `UDW_CYC(`UDW_STORE_CYCLE_NS)
) (
    // Clock and reset
    input  wire                  mclk,
    input  wire                  rst,
    // Command port
    input  wire                  cmd_valid,
    output wire                  cmd_ready,
    input  wire                  cmd_chan,
    input  wire [1:0]            cmd_op,
    input  wire                  cmd_up,
    // Shadow wiper positions and busy flag
    output reg  [`UDW_POS_W-1:0] pos0,
    output reg  [`UDW_POS_W-1:0] pos1,
    output reg                   busy,
    // Device pins, per channel
    output reg                   sel0_n,
    output reg                   step0_n,
    output reg                   dir0,
    output reg                   sel1_n,
    output reg                   step1_n,
    output reg                   dir1
);
    localparam [6:0] S_IDLE  = 7'h01;
    localparam [6:0] S_SETUP = 7'h02;
    localparam [6:0] S_LOW   = 7'h04;
    localparam [6:0] S_HIGH  = 7'h08;
    localparam [6:0] S_TAIL  = 7'h10;
    localparam [6:0] S_RISE  = 7'h20;
    localparam [6:0] S_WAIT  = 7'h40;

    reg  [6:0]            state;
    reg  [6:0]            next_state;
    reg                   chan;
    reg  [1:0]            op;
    reg                   up;
    reg                   selected;
    reg                   t_load;
    reg  [`UDW_CNT_W-1:0] t_value;
    wire                  t_done;

    // Shadow step, clamped like the device counter.
    function [`UDW_POS_W-1:0] sat_step;
        input [`UDW_POS_W-1:0] p;
        input                  dir_up;
        begin
            if (dir_up) begin
                sat_step = (p == `UDW_POS_MAX) ? p : p + 5'h01;
            end else begin
                sat_step = (p == 5'h00) ? p : p - 5'h01;
            end
        end
    endfunction

    function [`UDW_CNT_W-1:0] cyc;
        input integer n;
        begin
            cyc = n[`UDW_CNT_W-1:0];
        end
    endfunction

    udw_timer u_timer (
        .mclk  (mclk),
        .rst   (rst),
        .load  (t_load),
        .value (t_value),
        .done  (t_done)
    );

    assign cmd_ready = (state == S_IDLE) && t_done;

    always @* begin
        next_state = state;
        t_load     = 1'b0;
        t_value    = {`UDW_CNT_W{1'b0}};
        case (state)
            S_IDLE: begin
                if (cmd_valid && t_done) begin
                    if (cmd_op == `UDW_OP_STEP) begin
                        next_state = S_HIGH;
                        t_load     = 1'b1;
                        t_value    = cyc(`UDW_CYC(`UDW_STEP_HIGH_NS));
                    end else if (selected) begin
                        next_state = S_SETUP;
                        t_load     = 1'b1;
                        t_value    = cyc(`UDW_CYC(`UDW_CS_TO_STEP_NS));
                    end
                end
            end
            S_SETUP: begin
                if (t_done) begin
                    if (op == `UDW_OP_STEP) begin
                        next_state = S_LOW;
                        t_value    = cyc(`UDW_CYC(`UDW_STEP_LOW_NS));
                    end else begin
                        next_state = S_TAIL;
                        t_value    = cyc(`UDW_CYC(`UDW_STEP_TO_CS_NS));
                    end
                    t_load = 1'b1;
                end
            end
            S_LOW: begin
                if (t_done) begin
                    next_state = S_IDLE;
                end
            end
            S_HIGH: begin
                if (t_done) begin
                    next_state = S_SETUP;
                    t_load     = 1'b1;
                    t_value    = cyc(`UDW_CYC(`UDW_DIR_SETUP_NS));
                end
            end
            S_TAIL: begin
                if (t_done) begin
                    next_state = S_RISE;
                end
            end
            S_RISE: begin
                next_state = S_WAIT;
                t_load     = 1'b1;
                if (op == `UDW_OP_END_STORE) begin
                    t_value = cyc(STORE_CYCLES);
                end else begin
                    t_value = cyc(`UDW_CYC(`UDW_DESEL_NOSTORE_NS));
                end
            end
            S_WAIT: begin
                next_state = S_IDLE;
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    always @(posedge mclk) begin
        if (rst) begin
            state    <= S_IDLE;
            chan     <= 1'b0;
            op       <= `UDW_OP_STEP;
            up       <= 1'b0;
            selected <= 1'b0;
            pos0     <= 5'h00;
            pos1     <= 5'h00;
            busy     <= 1'b0;
            sel0_n   <= 1'b1;
            sel1_n   <= 1'b1;
            step0_n  <= 1'b1;
            step1_n  <= 1'b1;
            dir0     <= 1'b0;
            dir1     <= 1'b0;
        end else begin
            state <= next_state;
            busy  <= (next_state != S_IDLE) || !t_done;
            case (state)
                S_IDLE: begin
                    if (cmd_valid && t_done &&
                        (cmd_op == `UDW_OP_STEP || selected)) begin
                        op <= cmd_op;
                        up <= cmd_up;
                        if (cmd_op == `UDW_OP_STEP) begin
                            // Select, and lift a step pin left low by the last step.
                            chan <= cmd_chan;
                            if (cmd_chan) begin
                                sel1_n  <= 1'b0;
                                step1_n <= 1'b1;
                            end else begin
                                sel0_n  <= 1'b0;
                                step0_n <= 1'b1;
                            end
                            selected <= 1'b1;
                        end else if (cmd_op == `UDW_OP_END_STORE) begin
                            // Step must be high well before select rises to store.
                            if (chan) begin
                                step1_n <= 1'b1;
                            end else begin
                                step0_n <= 1'b1;
                            end
                        end
                    end
                end
                S_SETUP: begin
                    if (t_done && op == `UDW_OP_STEP) begin
                        if (chan) begin
                            step1_n <= 1'b0;
                            pos1    <= sat_step(pos1, up);
                        end else begin
                            step0_n <= 1'b0;
                            pos0    <= sat_step(pos0, up);
                        end
                    end
                end
                S_HIGH: begin
                    // Direction moves only once step has been high a while.
                    if (t_done) begin
                        if (chan) begin
                            dir1 <= up;
                        end else begin
                            dir0 <= up;
                        end
                    end
                end
                S_LOW, S_TAIL: begin
                    // Step stays low after a step, so a later select rise skips the store;
                    // lowering it again while selected would move the wiper once more.
                end
                S_RISE: begin
                    // Select rises only after the step phase is settled, never as a move.
                    sel0_n   <= 1'b1;
                    sel1_n   <= 1'b1;
                    selected <= 1'b0;
                end
                S_WAIT: begin
                    step0_n <= 1'b1;
                    step1_n <= 1'b1;
                end
                default: begin
                    step0_n <= 1'b1;
                    step1_n <= 1'b1;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- hdl/udw_timer.v ----
// Purpose: Down counter giving the least wait between pin phases.
// Assumes: Load and count share mclk; one tick per cycle.
// Notes:   done is high while the count is zero.
`timescale 1ns/1ps
`default_nettype none
`include "udw_consts.vh"
module udw_timer (
    // Clock and reset
    input  wire                  mclk,
    input  wire                  rst,
    // Control
    input  wire                  load,
    input  wire [`UDW_CNT_W-1:0] value,
    output wire                  done
);
    reg [`UDW_CNT_W-1:0] count;
    assign done = (count == {`UDW_CNT_W{1'b0}});
    always @(posedge mclk) begin
        if (rst) begin
            count <= {`UDW_CNT_W{1'b0}};
        end else if (load) begin
            count <= value;
        end else if (!done) begin
            count <= count - {{(`UDW_CNT_W-1){1'b0}}, 1'b1};
        end
    end
endmodule
`default_nettype wire
